// ===== logic/rpc_top.sv
/*
  Railroad preemption and safety supervisor of a traffic signal controller.
  Assumes pin inputs asynchronous to clk_i, AXI4-Lite master on clk_i.
*/
// The AXI4-Lite interface to the registers and the address map were decided locally.
// Summary of operation
// - Up to six preempt demands served by fixed priority; activation fails safe. Only the railroad demand is served here; low_pre_i is not decoded.
// - Each new railroad demand reserves track clearance green after current clearances.
// - Pedestrian flashing don't walk runs with and as long as the yellow.
// - Momentary test input calls the railroad routine like a real demand.
// - Normal operation only while series loop complete; open loop forces flash.
// - Failed interconnect: one track clearance green, flash after its red, latched.
// - Supervision component failures are treated as failures, fail safe.
// - Any interconnect failure raises a supervisory failure alarm.
// - Flash output is inverted so non-railroad controllers cannot run signals.
// - Loop component removal gives flashing red, latched until manual reset.
// - 16-bit signature of protected data checked at least once per second.
// - Signature mismatch forces all-red flash, CRC alarm, manual restart.
// - Protected writes only in flash; restart and verify before operation.
// - Primary and secondary preempt inputs are complementary from the cabinet.
// - Inputs equal over one second: input failure, clearance, flash, alarm.
// - Track clearance green within the maximum time, then a full interval.
// - Demand dropped and reapplied during sequence restarts full track clearance.
// - Repeated demands served without limit, built in.
// - Supervisory preemptor beats railroad, railroad beats all other preempts. There is no supervisory preemptor here, and low_pre_i is not decoded.
`timescale 1ns/10ps

module rpc_top
  import rpc_pkg::*;
#(
  parameter int unsigned TCG_N    = rpc_pkg::TCG_CYC,
  parameter int unsigned YEL_N    = rpc_pkg::YEL_CYC,
  parameter int unsigned RED_N    = rpc_pkg::RED_CYC,
  parameter int unsigned FAIL_N   = rpc_pkg::FAIL_CYC,
  parameter int unsigned VERIFY_N = rpc_pkg::VERIFY_CYC,
  parameter int unsigned MAXTCG_N = rpc_pkg::MAX_TCG_CYC
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  // Cabinet pins
  input  wire logic                pre_pri_i,     // Primary railroad demand
  input  wire logic                pre_sec_i,     // Secondary, on when idle
  input  wire logic                sup_ok_i,      // Interconnect supervision good
  input  wire logic                sup_chk_i,     // Supervision self check tone
  input  wire logic                test_i,        // Cabinet test switch
  input  wire logic                loop_ok_i,     // 24 V series loop complete
  input  wire logic                man_reset_i,   // Manual reset
  input  wire logic [3:0]          low_pre_i,     // Emergency, bus and other preempts
  input  wire logic [15:0]         hw_sig_i,      // Hardwired signature
  // Register bus
  input  wire rpc_pkg::rpc_axi_req_t axi_i,
  output rpc_pkg::rpc_axi_rsp_t    axi_o,
  // Signal and alarm outputs
  output rpc_pkg::rpc_sig_t        sig_o,
  output rpc_pkg::rpc_alarm_t      alarm_o,
  output logic                     relay_o        // Interface relay energized
);
  import rpc_pkg::*;

  // CRC-16 step over one 16-bit word
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step

  typedef struct packed {
    logic [5:0]   s1;       // First sync stage of the six pin bits
    logic [5:0]   s2;       // Second sync stage
    logic         man1;     // Manual reset, first sync stage
    logic         man2;     // Manual reset, second sync stage
    logic [15:0]  sig1;
    logic [15:0]  sig2;
    rpc_state_t   st;
    logic [31:0]  tmr;      // Interval timer
    logic [31:0]  mis;      // Time primary and secondary are equal
    logic [31:0]  ver;      // Signature check timer
    logic [31:0]  tcg_wait; // Time since demand without track green
    logic [7:0]   sup_cnt;  // Cycles since last supervision toggle
    logic         sup_prev;
    logic         dem_prev;
    logic         reserve;  // Pending track clearance reservice
    logic         fault_exit; // Flash at end of track clearance red
    logic [15:0]  crc;
    logic         restart_req; // Manual restart outstanding
    logic         run;
    rpc_alarm_t   alarm;
    logic         aw_got;
    logic         w_got;
    logic [7:0]   awa;
    logic [31:0]  wd;
    rpc_axi_rsp_t rsp;
    rpc_sig_t     sig;
    logic         relay;
  } rpc_regs_t;

  rpc_regs_t q;
  rpc_regs_t next_q;

  logic pri, sec, sup, chk, tst, loop;
  logic demand, in_fail, sup_fail, flt_any;

  // Synchronised pin view
  assign pri  = q.s2[0];
  assign sec  = q.s2[1];
  assign sup  = q.s2[2];
  assign chk  = q.s2[3];
  assign tst  = q.s2[4];
  assign loop = q.s2[5];

  // Railroad demand from primary input or test switch
  assign demand   = (pri & ~sec) | tst;
  assign in_fail  = (pri == sec);
  // Supervision fails on bad cable or stalled self check
  assign sup_fail = ~sup | (q.sup_cnt == 8'hff);
  assign flt_any  = q.alarm.sup_fail | q.alarm.input_fail | q.alarm.crc_fail
                    | q.alarm.loop_fail;

  // Next state
  always_comb begin
    next_q = q;
    next_q.s1   = {loop_ok_i, test_i, sup_chk_i, sup_ok_i, pre_sec_i, pre_pri_i};
    next_q.s2   = q.s1;
    next_q.man1 = man_reset_i;
    next_q.man2 = q.man1;
    next_q.sig1 = hw_sig_i;
    next_q.sig2 = q.sig1;
    next_q.dem_prev = demand;
    next_q.sup_prev = chk;
    next_q.sup_cnt  = (chk != q.sup_prev) ? 8'h00
                      : ((q.sup_cnt == 8'hff) ? q.sup_cnt : q.sup_cnt + 8'h01);
    next_q.tmr = (q.tmr == 32'h0) ? 32'h0 : q.tmr - 32'h1;

    // Input verification timer
    if (in_fail) begin
      next_q.mis = q.mis + 32'h1;
    end else begin
      next_q.mis = 32'h0;
    end
    if (q.mis >= FAIL_N) begin
      next_q.alarm.input_fail = 1'b1;
    end
    if (sup_fail) begin
      next_q.alarm.sup_fail = 1'b1;
    end
    if (!loop) begin
      next_q.alarm.loop_fail = 1'b1;
    end

    // Signature verification in run mode
    next_q.ver = (q.ver >= VERIFY_N - 1) ? 32'h0 : q.ver + 32'h1;
    if (q.run && q.ver == 32'h0 && q.crc != q.sig2) begin
      next_q.alarm.crc_fail = 1'b1;
    end

    // Manual reset clears only faults that are no longer present
    if (q.man2) begin
      if (sup && q.sup_cnt != 8'hff) next_q.alarm.sup_fail = 1'b0;
      if (!in_fail && q.mis < FAIL_N) next_q.alarm.input_fail = 1'b0; // Set wins
      if (loop) next_q.alarm.loop_fail = 1'b0;
      if (q.crc == q.sig2) next_q.alarm.crc_fail = 1'b0;
    end

    // Reservice on each new demand; a clear in the sequence below wins
    if (demand && !q.dem_prev) begin
      next_q.reserve = 1'b1;
    end
    // Failed input or cable: one last track clearance then flash
    if ((sup_fail || q.mis >= FAIL_N) && q.st != RPC_FLASH) begin
      if (!q.fault_exit) next_q.reserve = 1'b1;
      next_q.fault_exit = 1'b1;
    end
    next_q.tcg_wait = (q.reserve && q.st != RPC_TCG) ? q.tcg_wait + 32'h1 : 32'h0;

    // Sequence
    case (q.st)
      RPC_NORMAL: begin
        if (q.alarm.crc_fail || q.alarm.loop_fail || !q.run) begin
          next_q.st = RPC_FLASH;
        end else if (q.reserve) begin
          next_q.st  = RPC_YELLOW;
          next_q.tmr = YEL_N - 32'h1; // Timer runs down to zero inclusive
        end
      end
      RPC_YELLOW: begin
        if (q.tmr == 32'h0) begin
          next_q.st  = RPC_RED;
          next_q.tmr = RED_N - 32'h1;
        end
      end
      RPC_RED: begin
        if (q.tmr == 32'h0 || q.tcg_wait >= MAXTCG_N) begin
          next_q.st      = RPC_TCG;
          next_q.tmr     = TCG_N - 32'h1;
          next_q.reserve = 1'b0;
        end
      end
      RPC_TCG: begin
        if (q.reserve) begin
          next_q.tmr     = TCG_N - 32'h1;
          next_q.reserve = 1'b0;
        end else if (q.tmr == 32'h0) begin
          next_q.st  = RPC_TCR;
          next_q.tmr = RED_N - 32'h1;
        end
      end
      RPC_TCR: begin
        if (q.tmr == 32'h0) begin
          next_q.st = q.fault_exit ? RPC_FLASH : RPC_HOLD;
        end
      end
      RPC_HOLD: begin
        if (q.reserve) begin
          next_q.st  = RPC_YELLOW;
          next_q.tmr = YEL_N - 32'h1;
        end else if (!demand) begin
          next_q.st = RPC_NORMAL;
        end
      end
      RPC_FLASH: begin
        if (q.reserve && !q.fault_exit && q.run && !flt_any) begin
          next_q.st = RPC_NORMAL;
        end
        if (!flt_any) next_q.fault_exit = 1'b0;
        next_q.reserve = 1'b0;
      end
      default: next_q.st = RPC_FLASH;
    endcase
    if (next_q.st == RPC_FLASH && q.st != RPC_FLASH) begin
      next_q.run = 1'b0;
    end
    if (q.st == RPC_FLASH && q.run && !flt_any) begin
      next_q.st = RPC_NORMAL;
    end

    // AXI4-Lite write
    if (axi_i.awvalid && q.rsp.awready) begin
      next_q.aw_got      = 1'b1;
      next_q.awa         = axi_i.awaddr;
      next_q.rsp.awready = 1'b0;
    end
    if (axi_i.wvalid && q.rsp.wready) begin
      next_q.w_got     = 1'b1;
      next_q.wd        = axi_i.wdata;
      next_q.rsp.wready = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.rsp.bvalid) begin
      next_q.rsp.bvalid = 1'b1;
      next_q.rsp.bresp  = RESP_OK;
      next_q.aw_got     = 1'b0;
      next_q.w_got      = 1'b0;
      case (q.awa)
        ADDR_CTRL: begin
          // Restart allowed only in flash with matching signature
          if (q.wd[CTRL_RUN_BIT] && q.st == RPC_FLASH && q.crc == q.sig2 && !flt_any) begin
            next_q.run = 1'b1;
          end else if (!q.wd[CTRL_RUN_BIT]) begin
            next_q.run = 1'b0;
          end
        end
        ADDR_SIG: begin
          if (q.st == RPC_FLASH && !q.run) begin
            next_q.crc = crc_step(q.crc, q.wd[15:0]);
          end else begin
            next_q.rsp.bresp = RESP_SLV;
          end
        end
        ADDR_CRC: begin
          if (q.st == RPC_FLASH && !q.run) begin
            next_q.crc = CRC_INIT;
          end else begin
            next_q.rsp.bresp = RESP_SLV;
          end
        end
        default: next_q.rsp.bresp = RESP_SLV;
      endcase
    end
    if (q.rsp.bvalid && axi_i.bready) begin
      next_q.rsp.bvalid  = 1'b0;
      next_q.rsp.awready = 1'b1;
      next_q.rsp.wready  = 1'b1;
    end

    // AXI4-Lite read
    if (axi_i.arvalid && q.rsp.arready) begin
      next_q.rsp.arready = 1'b0;
      next_q.rsp.rvalid  = 1'b1;
      next_q.rsp.rresp   = RESP_OK;
      case (axi_i.araddr)
        ADDR_CTRL: next_q.rsp.rdata = {31'h0, q.run};
        ADDR_STAT: next_q.rsp.rdata = {21'h0, q.st, q.reserve, q.fault_exit, q.relay,
                                       q.alarm};
        ADDR_CRC:  next_q.rsp.rdata = {q.sig2, q.crc};
        ADDR_SIG:  next_q.rsp.rdata = 32'h0;
        default: begin
          next_q.rsp.rdata = 32'h0;
          next_q.rsp.rresp = RESP_SLV;
        end
      endcase
    end
    if (q.rsp.rvalid && axi_i.rready) begin
      next_q.rsp.rvalid  = 1'b0;
      next_q.rsp.arready = 1'b1;
    end

    // Outputs from next state; relay from demand and loop
    next_q.sig.tcg     = (next_q.st == RPC_TCG);
    next_q.sig.yellow  = (next_q.st == RPC_YELLOW);
    next_q.sig.ped_fdw = (next_q.st == RPC_YELLOW);
    next_q.sig.red     = (next_q.st == RPC_RED) || (next_q.st == RPC_TCR)
                         || (next_q.st == RPC_FLASH);
    next_q.sig.flash_n = (next_q.st != RPC_FLASH);
    next_q.alarm.flash = (next_q.st == RPC_FLASH);
    next_q.relay       = !demand && loop;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q             <= '0;
      q.st          <= RPC_FLASH;
      q.crc         <= CRC_INIT;
      q.s1          <= SYNC_IDLE; // No false fault right after reset
      q.s2          <= SYNC_IDLE;
      q.rsp.awready <= 1'b1;
      q.rsp.wready  <= 1'b1;
      q.rsp.arready <= 1'b1;
      q.sig.red     <= 1'b1;
      q.alarm.flash <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign axi_o   = q.rsp;
  assign sig_o   = q.sig;
  assign alarm_o = q.alarm;
  assign relay_o = q.relay;

  // Flashing don't walk only together with yellow
  a_fdw_with_yel: assert property (@(posedge clk_i) disable iff (srst_i)
    sig_o.ped_fdw |-> sig_o.yellow)
    else $error("flashing dont walk outside yellow");

  // Flash output low whenever flashing red
  a_flash_inv: assert property (@(posedge clk_i) disable iff (srst_i)
    alarm_o.flash |-> (!sig_o.flash_n && sig_o.red))
    else $error("flash output not inverted");

  // CRC alarm forces flash soon after
  a_crc_flash: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(q.alarm.crc_fail) |-> ##[1:3] alarm_o.flash)
    else $error("crc failure without flash");

  // Loop alarm forces flash outside track clearance sequence
  a_loop_flash: assert property (@(posedge clk_i) disable iff (srst_i)
    (q.alarm.loop_fail && q.st == RPC_NORMAL) |=> alarm_o.flash)
    else $error("open loop without flash");

  // Green follows yellow and red
  a_tcg_entry: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(sig_o.tcg) |-> $past(q.st) == RPC_RED)
    else $error("track green without clearance");

  // Signals only run when the run latch is set
  a_run_gate: assert property (@(posedge clk_i) disable iff (srst_i)
    (q.st == RPC_NORMAL) |-> $past(q.run))
    else $error("normal operation without restart");

  // Supervision fault raises alarm
  a_sup_alarm: assert property (@(posedge clk_i) disable iff (srst_i)
    (!sup) |=> q.alarm.sup_fail)
    else $error("supervision fault without alarm");

  // Fault exit ends in flash after clearance red
  a_fault_exit: assert property (@(posedge clk_i) disable iff (srst_i)
    (q.st == RPC_TCR && q.tmr == 32'h0 && q.fault_exit) |=> q.st == RPC_FLASH)
    else $error("fault exit missed flash");

endmodule : rpc_top

// ===== inc/rpc_pkg.sv
/*
  Package of the railroad preemption supervisor: constants, register map,
  state enumeration and the signal, alarm and bus carriers.
  Assumes a 50 MHz system clock.
*/
package rpc_pkg;

  // System clock rate and timing base
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned FAIL_TIME_MS   = 1000;   // Input equality limit
  localparam int unsigned VERIFY_TIME_MS = 1000;   // Longest gap between signature checks
  localparam int unsigned MAX_TCG_S      = 8;      // Max time to track clearance green
  localparam int unsigned FAIL_CYC       = (CLK_HZ / 1000) * FAIL_TIME_MS;
  localparam int unsigned VERIFY_CYC     = (CLK_HZ / 1000) * VERIFY_TIME_MS;
  localparam int unsigned MAX_TCG_CYC    = CLK_HZ * MAX_TCG_S;

  // Default durations in cycles (module parameters shorten them)
  localparam int unsigned TCG_CYC        = CLK_HZ * 10;  // Track clearance green
  localparam int unsigned YEL_CYC        = CLK_HZ * 4;   // Vehicle yellow
  localparam int unsigned RED_CYC        = CLK_HZ * 2;   // Red clearance

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL  = 8'h00;  // Bit0 run request, other bits ignored
  localparam logic [7:0] ADDR_SIG   = 8'h04;  // Protected data word (signature input)
  localparam logic [7:0] ADDR_STAT  = 8'h08;  // Status and alarms
  localparam logic [7:0] ADDR_CRC   = 8'h0c;  // Computed signature

  // Field positions
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_WR_BIT  = 1;

  // Reset values, CRC polynomial and response codes
  localparam logic [15:0] CRC_INIT  = 16'hffff;
  localparam logic [15:0] CRC_POLY  = 16'h1021;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;
  localparam logic [5:0]  SYNC_IDLE = 6'h26;  // Pins at rest: loop, supervision, secondary high

  // Sequence of the preemption engine
  typedef enum logic [2:0] {
    RPC_NORMAL,
    RPC_YELLOW,
    RPC_RED,
    RPC_TCG,
    RPC_TCR,
    RPC_HOLD,
    RPC_FLASH
  } rpc_state_t;

  // Signal outputs toward load switches
  typedef struct packed {
    logic tcg;        // Track clearance green on
    logic yellow;     // Vehicle yellow on
    logic red;        // Red on
    logic ped_fdw;    // Flashing don't walk
    logic flash_n;    // Inverted flash output (low = flash)
  } rpc_sig_t;

  // Alarms
  typedef struct packed {
    logic sup_fail;
    logic input_fail;
    logic crc_fail;
    logic loop_fail;
    logic flash;
  } rpc_alarm_t;

  // AXI4-Lite request and response carriers
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } rpc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rpc_axi_rsp_t;

endpackage : rpc_pkg

// ===== testbench/rpc_rail_model.sv
/*
  Crossing equipment and cabinet wiring model: complementary demand pair,
  interconnect cable supervision and the supervision self-check tone.
  Assumes the bench clock; scenario controls come from the bench.
*/
`timescale 1ns/10ps

module rpc_rail_model (
  // Clock
  input  wire logic       clk_i,
  // Scenario controls
  input  wire logic       demand_i,   // Crossing flashers running
  input  wire logic [1:0] fault_i,    // 1 both inputs on, 2 both off
  input  wire logic       cut_i,      // Interconnect cable broken
  input  wire logic       stop_i,     // Self-check tone stuck
  // Cabinet pins
  output logic            pri_o,
  output logic            sec_o,
  output logic            sup_ok_o,
  output logic            chk_o
);
  logic [6:0] cnt = 7'h0;

  // Demand starts with the flashers and ends as the gates rise
  always @(posedge clk_i) begin
    pri_o    <= (demand_i || fault_i == 2'd1) && fault_i != 2'd2;
    sec_o    <= (!demand_i || fault_i == 2'd1) && fault_i != 2'd2;
    sup_ok_o <= !cut_i;
    if (!stop_i) begin
      cnt <= cnt + 7'h1;
    end
  end

  // Tone toggles every 64 cycles, well inside the supervision window
  assign chk_o = cnt[6];

endmodule : rpc_rail_model

// ===== testbench/testbench.sv
/*
  Self-checking bench of the railroad preemption supervisor: register bus,
  preemption sequences, and latched faults with manual reset and restart.
  Assumes rpc_top with shortened counts and the crossing model.
*/
`timescale 1ns/10ps

module testbench;
  import rpc_pkg::*;
  localparam int unsigned TCG  = 20;
  localparam int unsigned YEL  = 5;
  localparam int unsigned RED  = 5;
  localparam int unsigned FLN  = 10;
  localparam int unsigned VER  = 20;
  localparam int unsigned MAXT = 30;

  logic         clk_i;
  logic         srst_i;
  logic         test_i;
  logic         loop_ok;
  logic         man_rst;
  logic         demand;
  logic         cut;
  logic         stop;
  logic         mon;
  logic [1:0]   fault;
  logic [3:0]   low_pre;
  logic [15:0]  hw_sig;
  logic         pri;
  logic         sec;
  logic         sup_ok;
  logic         sup_chk;
  logic         relay;
  rpc_axi_req_t req;
  rpc_axi_rsp_t rsp;
  rpc_sig_t     sig;
  rpc_alarm_t   alm;
  int           bad_count;
  int           n_checks;
  int           seed;
  int           run;
  logic [1:0]   resp;
  logic [31:0]  rd;
  int           al[6] = '{2, 2, 5, 5, 4, 3};
  int           lim[6] = '{FLN + 8, FLN + 8, 12, 300, 12, VER + 8};

  rpc_top #(.TCG_N(TCG), .YEL_N(YEL), .RED_N(RED), .FAIL_N(FLN), .VERIFY_N(VER),
            .MAXTCG_N(MAXT)) i_dut (
    .clk_i(clk_i), .srst_i(srst_i), .pre_pri_i(pri), .pre_sec_i(sec),
    .sup_ok_i(sup_ok), .sup_chk_i(sup_chk), .test_i(test_i), .loop_ok_i(loop_ok),
    .man_reset_i(man_rst), .low_pre_i(low_pre), .hw_sig_i(hw_sig), .axi_i(req),
    .axi_o(rsp), .sig_o(sig), .alarm_o(alm), .relay_o(relay));

  rpc_rail_model i_rail (
    .clk_i(clk_i), .demand_i(demand), .fault_i(fault), .cut_i(cut), .stop_i(stop),
    .pri_o(pri), .sec_o(sec), .sup_ok_o(sup_ok), .chk_o(sup_chk));

  // Clock of 20 ns
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Selects one watched output: tcg, flash, input, crc, loop, supervision
  function automatic logic pick(input int k);
    logic [5:0] v;
    v = {alm.sup_fail, alm.loop_fail, alm.crc_fail, alm.input_fail, ~sig.flash_n, sig.tcg};
    return v[k];
  endfunction : pick

  task automatic wait_bit(input string nm, input int k, input int n);
    int t;
    t = 0;
    while (pick(k) !== 1'b1 && t < n) begin
      @(negedge clk_i);
      t++;
    end
    chk(nm, 32'h1, {31'h0, pick(k)});
  endtask : wait_bit

  // Length of the next track clearance green
  task automatic tcg_len(output int n);
    n = 0;
    wait_bit("tcg start", 0, MAXT + 6);
    while (sig.tcg === 1'b1 && n < 500) begin
      @(negedge clk_i);
      n++;
    end
  endtask : tcg_len

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_i);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (req.awvalid && rsp.awready) begin
        aw_done = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (req.wvalid && rsp.wready) begin
        w_done = 1'b1;
        req.wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done && rsp.bvalid === 1'b1));
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (rsp.arready) begin
        req.arvalid <= 1'b0;
      end
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : axi_rd

  // Manual reset, strap the signature, then software restart
  task automatic restart;
    @(posedge clk_i);
    man_rst <= 1'b1;
    @(posedge clk_i);
    man_rst <= 1'b0;
    axi_rd(ADDR_CRC, rd, resp);
    hw_sig <= rd[15:0];
    repeat (4) @(posedge clk_i);
    axi_wr(ADDR_CTRL, 32'h1, resp);
    chk("run resp", RESP_OK, resp);
    repeat (4) @(negedge clk_i);
    chk("flash_n run", 32'h1, sig.flash_n);
    chk("relay idle", 32'h1, relay);
    axi_rd(ADDR_STAT, rd, resp);
    chk("stat run", 32'h20, rd);
  endtask : restart

  task automatic set_fault(input int k, input logic on);
    @(posedge clk_i);
    case (k)
      0: fault <= on ? 2'd1 : 2'd0;
      1: fault <= on ? 2'd2 : 2'd0;
      2: cut <= on;
      3: stop <= on;
      4: loop_ok <= !on;
      default: hw_sig <= ~hw_sig;
    endcase
  endtask : set_fault

  // Pedestrian flashing don't walk tracks the yellow while preempting
  always @(negedge clk_i) begin
    if (mon) begin
      chk("ped fdw", {31'h0, sig.yellow}, {31'h0, sig.ped_fdw});
    end
  end

  // Watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    results;
  end

  initial begin
    seed = 32'h6e9e3759;
    req = '0;
    srst_i = 1'b1;
    test_i = 1'b0;
    loop_ok = 1'b1;
    man_rst = 1'b0;
    demand = 1'b0;
    cut = 1'b0;
    stop = 1'b0;
    mon = 1'b0;
    fault = 2'd0;
    low_pre = 4'h0;
    hw_sig = 16'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    @(negedge clk_i);
    chk("reset sig", 32'h04, sig);
    chk("reset alarm", 32'h01, alm);
    axi_rd(8'h10, rd, resp);
    chk("unmapped rresp", RESP_SLV, resp);
    chk("unmapped rdata", 32'h0, rd);
    axi_wr(8'h14, 32'h0, resp);
    chk("unmapped bresp", RESP_SLV, resp);
    axi_wr(ADDR_SIG, $random(seed), resp);
    chk("sig wr flash", RESP_OK, resp);
    axi_rd(ADDR_CRC, rd, resp);
    hw_sig <= ~rd[15:0];
    repeat (4) @(posedge clk_i);
    axi_wr(ADDR_CTRL, 32'h1, resp);
    repeat (4) @(negedge clk_i);
    chk("run on mismatch", 32'h0, sig.flash_n);
    restart;
    axi_wr(ADDR_SIG, 32'h0, resp);
    chk("sig wr run", RESP_SLV, resp);
    // First demand, then repeated drops and returns through the sequence
    @(posedge clk_i);
    mon <= 1'b1;
    demand <= 1'b1;
    low_pre <= 4'($random(seed));
    tcg_len(run);
    chk("tcg full", TCG, run);
    repeat (RED + 4) @(negedge clk_i);
    chk("relay hold", 32'h0, relay);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      demand <= 1'b0;
      low_pre <= 4'($random(seed));
      repeat (2 + ($random(seed) & 7)) @(posedge clk_i);
      demand <= 1'b1;
      tcg_len(run);
      chk("tcg reservice", 32'h1, run >= TCG);
    end
    @(posedge clk_i);
    demand <= 1'b0;
    repeat (2 * RED + 8) @(negedge clk_i);
    chk("back to normal", 32'h1, sig.flash_n);
    chk("normal red", 32'h0, sig.red);
    @(posedge clk_i);
    test_i <= 1'b1;
    tcg_len(run);
    chk("test tcg", TCG, run);
    @(posedge clk_i);
    test_i <= 1'b0;
    repeat (2 * RED + 8) @(negedge clk_i);
    chk("test released", 32'h0, sig.tcg);
    mon <= 1'b0;
    // Latched faults: flash, alarm held through manual reset, then restart
    for (int k = 0; k < 6; k++) begin
      set_fault(k, 1'b1);
      wait_bit("alarm", al[k], lim[k]);
      if (k < 4) begin
        tcg_len(run);
        chk("fault tcg", 32'h1, run > 0);
      end
      wait_bit("flash", 1, TCG + 2 * RED + YEL + MAXT + 20);
      @(posedge clk_i);
      man_rst <= 1'b1;
      @(posedge clk_i);
      man_rst <= 1'b0;
      repeat (3) @(negedge clk_i);
      chk("alarm held", 32'h1, pick(al[k]));
      set_fault(k, 1'b0);
      repeat (120) @(posedge clk_i);
      restart;
      chk("alarm clear", 32'h0, pick(al[k]));
    end
    results;
  end

endmodule : testbench
